// *** design/cic_pkg.sv ***
// Shared constants and types for the charger interrupt-mask and converter
// control register block.
// Assumes a single 125 MHz clock domain and an I2C host on the pins.
package cic_pkg;

    // Clock and pulse timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int INT_PULSE_NS = 256;
    localparam int INT_PULSE_CYC_CALC = (INT_PULSE_NS * 1000) / CLK_PERIOD_PS;
    localparam int INT_PULSE_CYC = (INT_PULSE_CYC_CALC < 1) ? 1 :
                                   INT_PULSE_CYC_CALC;
    localparam int INT_CNT_W = 12;

    // Serial port
    localparam logic [6:0] DEV_ADDR_DEF = 7'h55;  // Arbitrary target address
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Register offsets
    localparam logic [7:0] OFS_CHARGE_STATE_IRQ_BLOCK_B = 8'h24;
    localparam logic [7:0] OFS_FAULT_MASK = 8'h25;
    localparam logic [7:0] OFS_CONV_CTRL = 8'h26;
    localparam logic [7:0] OFS_RESULT_LO = 8'h28;
    localparam logic [7:0] OFS_RESULT_HI = 8'h29;

    // Reset values and writable bits
    localparam logic [7:0] RST_CHARGE_STATE_IRQ_BLOCK_B = 8'h00;
    localparam logic [7:0] RST_FAULT_MASK = 8'h00;
    localparam logic [7:0] RST_CONV_CTRL = 8'h30;
    localparam logic [7:0] WMASK_CHARGE_STATE_IRQ_BLOCK_B = 8'h09;
    localparam logic [7:0] WMASK_FAULT_MASK = 8'hF9;
    localparam logic [7:0] WMASK_CONV_CTRL = 8'hFC;

    // Field positions: second charger mask register
    localparam int BIT_CHARGE_STATE_IRQ_BLOCK = 3;
    localparam int BIT_INPUT_SUPPLY_STATE_IRQ_BLOCK = 0;
    // Field positions: fault mask register
    localparam int BIT_INPUT_FAULT_IRQ_BLOCK = 7;
    localparam int BIT_BATTERY_FAULT_IRQ_BLOCK = 6;
    localparam int BIT_SYSTEM_RAIL_FAULT_IRQ_BLOCK = 5;
    localparam int BIT_OUTPUT_PATH_FAULT_IRQ_BLOCK = 4;
    localparam int BIT_DIE_OVERHEAT_IRQ_BLOCK = 3;
    localparam int BIT_TEMP_ZONE_IRQ_BLOCK = 0;
    // Field positions: converter control register
    localparam int BIT_CONV_ENABLE = 7;
    localparam int BIT_CONV_ONE_SHOT = 6;
    localparam int BIT_SPEED_HI = 5;
    localparam int BIT_SPEED_LO = 4;
    localparam int BIT_AVERAGING_SELECT = 3;
    localparam int BIT_AVERAGING_SEED_SELECT = 2;

    // Event vector indexes
    localparam int EV_CHARGE_STATE = 0;
    localparam int EV_INPUT_SUPPLY_STATE = 1;
    localparam int EV_INPUT_FAULT = 2;
    localparam int EV_BATTERY_FAULT = 3;
    localparam int EV_SYSTEM_RAIL_FAULT = 4;
    localparam int EV_OUTPUT_PATH_FAULT = 5;
    localparam int EV_DIE_OVERHEAT = 6;
    localparam int EV_TEMP_ZONE = 7;
    localparam int EV_COUNT = 8;

    // Converter
    localparam int SAMPLE_W = 12;
    localparam int RESULT_W = 16;
    localparam logic [RESULT_W-1:0] RESULT_POR = 16'h0000;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PTR_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RACK = 9'h100
    } cic_i2c_state_e;

endpackage

// *** design/cic_conv_if.sv ***
// Carrier between the register block and the converter result engine.
// Assumes both ends share clock_i.
`timescale 1ns/10ps
`default_nettype none
interface cic_conv_if;
    import cic_pkg::*;
    logic enable;
    logic one_shot;
    logic [1:0] speed;
    logic avg_on;
    logic seed_new;
    logic sample_valid;
    logic [SAMPLE_W-1:0] sample;
    logic [RESULT_W-1:0] result;
    logic pass_done;
    modport ctl (output enable, output one_shot, output speed, output avg_on,
                 output seed_new, output sample_valid, output sample,
                 input result, input pass_done);
    modport eng (input enable, input one_shot, input speed, input avg_on,
                 input seed_new, input sample_valid, input sample,
                 output result, output pass_done);
endinterface
`default_nettype wire

// *** design/cic_conv_engine.sv ***
// Converter result engine: resolution trim, averaging and one-shot control.
// Assumes samples arrive as one-cycle strobes on clock_i.
`timescale 1ns/10ps
`default_nettype none
module cic_conv_engine (
    input wire logic clock_i,
    input wire logic reset_i,
    cic_conv_if.eng conv
);
    import cic_pkg::*;

    typedef struct packed {
        logic [RESULT_W-1:0] result;
        logic avg_started;
        logic shot_taken;
        logic pass_done;
    } cic_eng_s;

    cic_eng_s st_r;
    cic_eng_s st_nxt;
    logic [SAMPLE_W-1:0] trim_mask;
    logic [RESULT_W-1:0] fresh;
    logic [RESULT_W:0] avg_sum;

    always_comb begin
        trim_mask = {SAMPLE_W{1'b1}} << conv.speed;
        fresh = RESULT_W'(conv.sample & trim_mask);
        avg_sum = {1'b0, st_r.result} + {1'b0, fresh};
        st_nxt = st_r;
        st_nxt.pass_done = 1'b0;
        if (!conv.enable) begin
            st_nxt.avg_started = 1'b0;
            st_nxt.shot_taken = 1'b0;
        end else if (conv.sample_valid && !st_r.shot_taken) begin
            if (!conv.avg_on || (!st_r.avg_started && conv.seed_new)) begin
                st_nxt.result = fresh;
            end else begin
                st_nxt.result = avg_sum[RESULT_W:1];
            end
            st_nxt.avg_started = conv.avg_on;
            if (conv.one_shot) begin
                st_nxt.shot_taken = 1'b1;
                st_nxt.pass_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '{result: RESULT_POR, default: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign conv.result = st_r.result;
    assign conv.pass_done = st_r.pass_done;
endmodule
`default_nettype wire

// *** design/cic_top.sv ***
// Charger interrupt-mask and converter control registers behind an I2C
// target port, with interrupt pulse generation.
// Assumes event strobes and samples come from logic on clock_i; SCL and SDA
// are asynchronous pins with an external pull-up on SDA.
`timescale 1ns/10ps
`default_nettype none
module cic_top #(
    parameter logic [6:0] DEV_ADDR = cic_pkg::DEV_ADDR_DEF,
    parameter int INT_PULSE_CYCLES = cic_pkg::INT_PULSE_CYC
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [cic_pkg::EV_COUNT-1:0] events_i,
    input wire logic flag_clear_i,
    input wire logic reg_reset_i,
    input wire logic watchdog_expired_i,
    input wire logic sample_valid_i,
    input wire logic [cic_pkg::SAMPLE_W-1:0] sample_i,
    output logic int_n_o,
    output logic [cic_pkg::EV_COUNT-1:0] flags_o,
    output logic conv_enable_o,
    output logic conv_one_shot_o,
    output logic [1:0] conv_speed_o,
    output logic [cic_pkg::RESULT_W-1:0] conv_result_o
);
    import cic_pkg::*;

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic scl_f;
        logic sda_f;
        cic_i2c_state_e state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic read_dir;
        logic host_nack;
        logic sda_low;
        logic sda_oe_n;
        logic [7:0] charge_state_irq_block_b;
        logic [7:0] fault_mask;
        logic [7:0] conv_ctrl;
        logic [EV_COUNT-1:0] flags;
        logic [INT_CNT_W-1:0] int_cnt;
        logic int_n;
        logic [RESULT_W-1:0] result_out;
    } cic_top_s;

    cic_top_s st_r;
    cic_top_s st_nxt;
    cic_conv_if conv ();

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [EV_COUNT-1:0] block_vec;
    logic [EV_COUNT-1:0] irq_events;
    logic [7:0] rd_byte;
    logic wr_strobe;
    logic [7:0] wr_data;

    localparam logic [INT_CNT_W-1:0] PULSE_LEN =
        INT_CNT_W'(INT_PULSE_CYCLES);

    function automatic logic [7:0] read_reg(input logic [7:0] ofs,
                                            input cic_top_s s);
        logic [7:0] val;
        val = 8'h00;
        if (ofs == OFS_CHARGE_STATE_IRQ_BLOCK_B) begin
            val = s.charge_state_irq_block_b & WMASK_CHARGE_STATE_IRQ_BLOCK_B;
        end else if (ofs == OFS_FAULT_MASK) begin
            val = s.fault_mask & WMASK_FAULT_MASK;
        end else if (ofs == OFS_CONV_CTRL) begin
            val = s.conv_ctrl & WMASK_CONV_CTRL;
        end else if (ofs == OFS_RESULT_LO) begin
            val = s.result_out[7:0];
        end else if (ofs == OFS_RESULT_HI) begin
            val = s.result_out[15:8];
        end
        return val;
    endfunction

    // Mask bit that blocks each event's interrupt pulse
    always_comb begin
        block_vec = '0;
        block_vec[EV_CHARGE_STATE] =
            st_r.charge_state_irq_block_b[BIT_CHARGE_STATE_IRQ_BLOCK];
        block_vec[EV_INPUT_SUPPLY_STATE] =
            st_r.charge_state_irq_block_b[BIT_INPUT_SUPPLY_STATE_IRQ_BLOCK];
        block_vec[EV_INPUT_FAULT] =
            st_r.fault_mask[BIT_INPUT_FAULT_IRQ_BLOCK];
        block_vec[EV_BATTERY_FAULT] =
            st_r.fault_mask[BIT_BATTERY_FAULT_IRQ_BLOCK];
        block_vec[EV_SYSTEM_RAIL_FAULT] =
            st_r.fault_mask[BIT_SYSTEM_RAIL_FAULT_IRQ_BLOCK];
        block_vec[EV_OUTPUT_PATH_FAULT] =
            st_r.fault_mask[BIT_OUTPUT_PATH_FAULT_IRQ_BLOCK];
        block_vec[EV_DIE_OVERHEAT] =
            st_r.fault_mask[BIT_DIE_OVERHEAT_IRQ_BLOCK];
        block_vec[EV_TEMP_ZONE] =
            st_r.fault_mask[BIT_TEMP_ZONE_IRQ_BLOCK];
    end

    genvar gi;
    generate
        for (gi = 0; gi < EV_COUNT; gi++) begin : g_gate
            assign irq_events[gi] = events_i[gi] & ~block_vec[gi];
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        wr_strobe = 1'b0;
        wr_data = st_r.shift;

        // Pin filtering: a change counts once the last two stages agree
        st_nxt.scl_sync = {st_r.scl_sync[1:0], scl_i};
        st_nxt.sda_sync = {st_r.sda_sync[1:0], sda_i};
        if (st_r.scl_sync[1] == st_r.scl_sync[2]) begin
            st_nxt.scl_f = st_r.scl_sync[2];
        end
        if (st_r.sda_sync[1] == st_r.sda_sync[2]) begin
            st_nxt.sda_f = st_r.sda_sync[2];
        end
        scl_rise = st_nxt.scl_f && !st_r.scl_f;
        scl_fall = !st_nxt.scl_f && st_r.scl_f;
        start_seen = st_r.scl_f && st_nxt.scl_f && st_r.sda_f &&
                     !st_nxt.sda_f;
        stop_seen = st_r.scl_f && st_nxt.scl_f && !st_r.sda_f &&
                    st_nxt.sda_f;
        rd_byte = read_reg(st_r.ptr, st_r);

        if (start_seen) begin
            st_nxt.state = ST_ADDR;
            st_nxt.bit_cnt = '0;
            st_nxt.sda_low = 1'b0;
        end else if (stop_seen) begin
            st_nxt.state = ST_IDLE;
            st_nxt.sda_low = 1'b0;
        end else if (scl_rise) begin
            case (st_r.state)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    st_nxt.shift = {st_r.shift[6:0], st_nxt.sda_f};
                    st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                end
                ST_RDATA: begin
                    st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                end
                ST_RACK: begin
                    st_nxt.host_nack = st_nxt.sda_f;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (st_r.state)
                ST_ADDR: begin
                    if (st_r.bit_cnt == BITS_PER_BYTE) begin
                        if (st_r.shift[7:1] == DEV_ADDR) begin
                            st_nxt.read_dir = st_r.shift[0];
                            st_nxt.sda_low = 1'b1;
                            st_nxt.state = ST_ADDR_ACK;
                        end else begin
                            st_nxt.state = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    st_nxt.bit_cnt = '0;
                    if (st_r.read_dir) begin
                        st_nxt.tx = rd_byte;
                        st_nxt.ptr = st_r.ptr + 8'h01;
                        st_nxt.sda_low = ~rd_byte[7];
                        st_nxt.state = ST_RDATA;
                    end else begin
                        st_nxt.sda_low = 1'b0;
                        st_nxt.state = ST_PTR;
                    end
                end
                ST_PTR: begin
                    if (st_r.bit_cnt == BITS_PER_BYTE) begin
                        st_nxt.ptr = st_r.shift;
                        st_nxt.sda_low = 1'b1;
                        st_nxt.state = ST_PTR_ACK;
                    end
                end
                ST_WDATA: begin
                    if (st_r.bit_cnt == BITS_PER_BYTE) begin
                        wr_strobe = 1'b1;
                        st_nxt.ptr = st_r.ptr + 8'h01;
                        st_nxt.sda_low = 1'b1;
                        st_nxt.state = ST_WACK;
                    end
                end
                ST_PTR_ACK, ST_WACK: begin
                    st_nxt.bit_cnt = '0;
                    st_nxt.sda_low = 1'b0;
                    st_nxt.state = ST_WDATA;
                end
                ST_RDATA: begin
                    if (st_r.bit_cnt == BITS_PER_BYTE) begin
                        st_nxt.sda_low = 1'b0;
                        st_nxt.state = ST_RACK;
                    end else begin
                        st_nxt.tx = {st_r.tx[6:0], 1'b0};
                        st_nxt.sda_low = ~st_r.tx[6];
                    end
                end
                ST_RACK: begin
                    st_nxt.bit_cnt = '0;
                    if (st_r.host_nack) begin
                        st_nxt.state = ST_IDLE;
                    end else begin
                        st_nxt.tx = rd_byte;
                        st_nxt.ptr = st_r.ptr + 8'h01;
                        st_nxt.sda_low = ~rd_byte[7];
                        st_nxt.state = ST_RDATA;
                    end
                end
                default: begin
                    st_nxt.sda_low = 1'b0;
                end
            endcase
        end

        // Register writes, reserved bits held at zero
        if (wr_strobe) begin
            if (st_r.ptr == OFS_CHARGE_STATE_IRQ_BLOCK_B) begin
                st_nxt.charge_state_irq_block_b = wr_data & WMASK_CHARGE_STATE_IRQ_BLOCK_B;
            end else if (st_r.ptr == OFS_FAULT_MASK) begin
                st_nxt.fault_mask = wr_data & WMASK_FAULT_MASK;
            end else if (st_r.ptr == OFS_CONV_CTRL) begin
                st_nxt.conv_ctrl = wr_data & WMASK_CONV_CTRL;
            end
        end

        // One-shot pass finished: enable drops
        if (conv.pass_done) begin
            st_nxt.conv_ctrl[BIT_CONV_ENABLE] = 1'b0;
        end
        if (watchdog_expired_i) begin
            st_nxt.conv_ctrl[BIT_CONV_ENABLE] = 1'b0;
        end
        if (reg_reset_i) begin
            st_nxt.charge_state_irq_block_b = RST_CHARGE_STATE_IRQ_BLOCK_B;
            st_nxt.fault_mask = RST_FAULT_MASK;
            st_nxt.conv_ctrl = RST_CONV_CTRL;
        end

        // Sticky flags ignore masks; a new event beats a clear
        st_nxt.flags = (st_r.flags & ~{EV_COUNT{flag_clear_i}}) |
                       events_i;

        // Active-low interrupt pulse, retriggered by any unmasked event
        if (|irq_events) begin
            st_nxt.int_cnt = PULSE_LEN;
            st_nxt.int_n = 1'b0;
        end else if (st_r.int_cnt > 1) begin
            st_nxt.int_cnt = st_r.int_cnt - 1'b1;
        end else begin
            st_nxt.int_cnt = '0;
            st_nxt.int_n = 1'b1;
        end

        st_nxt.sda_oe_n = ~st_nxt.sda_low;
        st_nxt.result_out = conv.result;
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
            st_r.scl_sync <= 3'h7;
            st_r.sda_sync <= 3'h7;
            st_r.scl_f <= 1'b1;
            st_r.sda_f <= 1'b1;
            st_r.state <= ST_IDLE;
            st_r.charge_state_irq_block_b <= RST_CHARGE_STATE_IRQ_BLOCK_B;
            st_r.fault_mask <= RST_FAULT_MASK;
            st_r.conv_ctrl <= RST_CONV_CTRL;
            st_r.int_n <= 1'b1;
            st_r.sda_oe_n <= 1'b1;
            st_r.result_out <= RESULT_POR;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Converter controls straight from the control register, sample strobe and data straight from the input pins
    assign conv.enable = st_r.conv_ctrl[BIT_CONV_ENABLE];
    assign conv.one_shot = st_r.conv_ctrl[BIT_CONV_ONE_SHOT];
    assign conv.speed = st_r.conv_ctrl[BIT_SPEED_HI:BIT_SPEED_LO];
    assign conv.avg_on = st_r.conv_ctrl[BIT_AVERAGING_SELECT];
    assign conv.seed_new = st_r.conv_ctrl[BIT_AVERAGING_SEED_SELECT];
    assign conv.sample_valid = sample_valid_i;
    assign conv.sample = sample_i;

    cic_conv_engine u_engine (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .conv(conv)
    );

    // Open-drain SDA: enable low pulls the wire low
    assign sda_o = 1'b0;
    assign sda_oe_n_o = st_r.sda_oe_n;
    assign int_n_o = st_r.int_n;
    assign flags_o = st_r.flags;
    assign conv_enable_o = st_r.conv_ctrl[BIT_CONV_ENABLE];
    assign conv_one_shot_o = st_r.conv_ctrl[BIT_CONV_ONE_SHOT];
    assign conv_speed_o = st_r.conv_ctrl[BIT_SPEED_HI:BIT_SPEED_LO];
    assign conv_result_o = st_r.result_out;
endmodule
`default_nettype wire

// *** sim/cic_props.sv ***
// Port checker for the mask and converter control block.
// Assumes a bind onto cic_top and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module cic_props #(
    parameter logic [6:0] DEV_ADDR = 7'h55,
    parameter int INT_PULSE_CYCLES = 32
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] events_i,
    input wire logic flag_clear_i,
    input wire logic reg_reset_i,
    input wire logic watchdog_expired_i,
    input wire logic sample_valid_i,
    input wire logic int_n_o,
    input wire logic [7:0] flags_o,
    input wire logic conv_enable_o,
    input wire logic conv_one_shot_o,
    input wire logic [1:0] conv_speed_o,
    input wire logic [15:0] conv_result_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    int low_r;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) low_r <= 0;
        else if (int_n_o || (|events_i)) low_r <= 0;
        else low_r <= low_r + 1;
    end
    property p_int_cause;
        $fell(int_n_o) |-> $past(|events_i);
    endproperty
    a_int_cause: assert property (p_int_cause)
        else $error("pulse w/o event");
    property p_int_min;
        $fell(int_n_o) |-> !int_n_o [*3];
    endproperty
    a_int_min: assert property (p_int_min)
        else $error("pulse too short");
    property p_int_max;
        low_r <= INT_PULSE_CYCLES;
    endproperty
    a_int_max: assert property (p_int_max)
        else $error("pulse too long");
    property p_flag_set;
        (|events_i) |=> ((flags_o & $past(events_i)) == $past(events_i));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag lost");
    property p_flag_clr;
        flag_clear_i && !(|events_i) |=> flags_o == 8'h00;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("flags kept");
    property p_wdog;
        watchdog_expired_i |=> !conv_enable_o;
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("enable kept");
    property p_rrst;
        reg_reset_i |=> !conv_enable_o && !conv_one_shot_o &&
            conv_speed_o == 2'h3;
    endproperty
    a_rrst: assert property (p_rrst)
        else $error("no defaults");
    property p_hold;
        $changed(conv_result_o) |-> $past(sample_valid_i) ||
            $past(sample_valid_i, 2) || $past(sample_valid_i, 3);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result moved");
endmodule
bind cic_top cic_props #(.DEV_ADDR(DEV_ADDR),
    .INT_PULSE_CYCLES(INT_PULSE_CYCLES)) props_u (.clock_i(clock_i),
    .reset_i(reset_i), .events_i(events_i), .flag_clear_i(flag_clear_i),
    .reg_reset_i(reg_reset_i), .watchdog_expired_i(watchdog_expired_i),
    .sample_valid_i(sample_valid_i), .int_n_o(int_n_o), .flags_o(flags_o),
    .conv_enable_o(conv_enable_o), .conv_one_shot_o(conv_one_shot_o),
    .conv_speed_o(conv_speed_o), .conv_result_o(conv_result_o));
`default_nettype wire

// *** sim/cic_host.sv ***
// Serial host model: open-drain data, driven clock, slow bit phases.
// Assumes a pull-up on the data wire, resolved by the bench.
`timescale 1ns/10ps
`default_nettype none
module cic_host (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    import cic_pkg::*;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic hp();
        repeat (10) @(negedge clock_i);
    endtask
    // Data moves only well after the clock fall, never near a clock edge
    task automatic bx(input logic b, output logic r);
        hp();
        sda_low_o = !b;
        hp();
        scl_o = 1'b1;
        hp();
        r = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic sta();
        hp();
        sda_low_o = 1'b0;
        hp();
        scl_o = 1'b1;
        hp();
        sda_low_o = 1'b1;
        hp();
        scl_o = 1'b0;
    endtask
    task automatic stp();
        hp();
        sda_low_o = 1'b1;
        hp();
        scl_o = 1'b1;
        hp();
        sda_low_o = 1'b0;
        hp();
    endtask
    task automatic xb(input logic [7:0] d, output logic [7:0] q,
                      output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
        bx(1'b1, r);
        a = !r;
    endtask
    task automatic wr(input logic [6:0] dv, input logic [7:0] o, d,
                      output logic ok);
        logic [7:0] q;
        logic a, b, c;
        sta();
        xb({dv, 1'b0}, q, a);
        xb(o, q, b);
        xb(d, q, c);
        stp();
        ok = a & b & c;
    endtask
    task automatic rd(input logic [7:0] o, output logic [7:0] q);
        logic a;
        sta();
        xb({DEV_ADDR_DEF, 1'b0}, q, a);
        xb(o, q, a);
        sta();
        xb({DEV_ADDR_DEF, 1'b1}, q, a);
        xb(8'hFF, q, a);
        stp();
    endtask
endmodule
`default_nettype wire

// *** sim/charger_irq_mask_adc_ctrl_test.sv ***
// Self-checking bench for cic_top driven through the serial host model.
// Assumes the checker is bound and the pulse length is set to 4.
`timescale 1ns/10ps
`default_nettype none
module charger_irq_mask_adc_ctrl_test;
    import cic_pkg::*;
    logic clock_i = 0, reset_i = 1, fc = 0, rr = 0, wd = 0, sv = 0;
    logic [7:0] ev = 0, flg;
    logic [11:0] smp = 0;
    logic sda_o, oe_n, int_n, en, os, scl, sda_low;
    logic [1:0] spd;
    logic [15:0] res;
    wire logic sda;
    int fails = 0, checks = 0, cyc = 0;
    int pos [8] = '{3, 0, 7, 6, 5, 4, 3, 0};
    assign sda = sda_low ? 1'b0 : (oe_n ? 1'b1 : sda_o);
    initial forever #4 clock_i = ~clock_i;
    cic_top #(.INT_PULSE_CYCLES(4)) dut_u (.clock_i(clock_i),
        .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n_o(oe_n), .events_i(ev), .flag_clear_i(fc),
        .reg_reset_i(rr), .watchdog_expired_i(wd), .sample_valid_i(sv),
        .sample_i(smp), .int_n_o(int_n), .flags_o(flg),
        .conv_enable_o(en), .conv_one_shot_o(os), .conv_speed_o(spd),
        .conv_result_o(res));
    cic_host host_u (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 90000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic wr(input logic [7:0] o, d);
        logic a;
        host_u.wr(DEV_ADDR_DEF, o, d, a);
        chk(a, 1'b1);
    endtask
    task automatic rd(input logic [7:0] o, exp);
        logic [7:0] q;
        host_u.rd(o, q);
        chk(q, exp);
    endtask
    task automatic evs(input logic [7:0] a, b);
        logic m;
        wr(8'h24, a);
        wr(8'h25, b);
        for (int i = 0; i < 8; i++) begin
            m = (i < 2) ? a[pos[i]] : b[pos[i]];
            w(8);
            fc = 1;
            w(1);
            fc = 0;
            ev[i] = 1;
            w(1);
            ev = 0;
            chk(int_n, m);
            chk(flg[i], 1'b1);
        end
        $display("test events %h %h done", a, b);
    endtask
    task automatic smpl(input logic [11:0] s, input logic [15:0] e);
        smp = s;
        sv = 1;
        w(1);
        sv = 0;
        w(4);
        chk(res, e);
    endtask
    initial begin
        w(16);
        reset_i = 0;
        w(5);
        chk(res, 16'h0000);
        chk({en, os, spd}, 4'h3);
        rd(8'h24, 8'h00);
        rd(8'h25, 8'h00);
        rd(8'h26, 8'h30);
        evs(8'hFF, 8'hFF);
        wr(8'h26, 8'hFF);
        rd(8'h24, 8'h09);
        rd(8'h25, 8'hF9);
        rd(8'h26, 8'hFC);
        chk({en, os, spd}, 4'hF);
        evs(8'h08, 8'hA8);
        evs(8'h01, 8'h51);
        wr(8'h26, 8'h80);
        smpl(12'hABC, 16'h0ABC);
        for (int s = 1; s < 4; s++) begin
            wr(8'h26, 8'(8'h80 | (s << 4)));
            smpl(12'hFFF, 16'(16'h0FFF & ~((16'h1 << s) - 1)));
        end
        wr(8'h26, 8'h88);
        smpl(12'h008, 16'h0800);
        wr(8'h26, 8'h00);
        wr(8'h26, 8'h8C);
        smpl(12'h100, 16'h0100);
        smpl(12'h300, 16'h0200);
        $display("test converter done");
        wr(8'h26, 8'hC0);
        smpl(12'h123, 16'h0123);
        chk(en, 1'b0);
        smpl(12'h456, 16'h0123);
        rd(8'h26, 8'h40);
        wr(8'h26, 8'h80);
        wd = 1;
        w(1);
        wd = 0;
        chk(en, 1'b0);
        rd(8'h26, 8'h00);
        $display("test one-shot and watchdog done");
        wr(8'h24, 8'h09);
        wr(8'h25, 8'hF9);
        wr(8'h26, 8'hFC);
        rr = 1;
        w(1);
        rr = 0;
        w(2);
        rd(8'h24, 8'h00);
        rd(8'h25, 8'h00);
        rd(8'h26, 8'h30);
        chk(res, 16'h0123);
        rd(8'h28, 8'h23);
        rd(8'h29, 8'h01);
        $display("test register reset done");
        end_sim();
    end
endmodule
`default_nettype wire
